//--- cip_pkg.sv
package cip_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [3:0] CIP_ADDR_STATUS   = 4'h0;  // Detection flags
   localparam logic [3:0] CIP_ADDR_ID_CODE  = 4'h1;  // Resistance code
   localparam logic [3:0] CIP_ADDR_INT      = 4'h2;  // Event flags, clear on read
   localparam logic [3:0] CIP_ADDR_INT_MASK = 4'h3;  // Event masks
   localparam logic [3:0] CIP_ADDR_SW_CTL1  = 4'h4;  // Signal switches
   localparam logic [3:0] CIP_ADDR_SW_CTL2  = 4'h5;  // Audio and power switch
   localparam logic [3:0] CIP_ADDR_TYPE     = 4'h6;  // Supply type and lock-out

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CIP_INT_EVENT_A  = 0;  // Event_a event
   localparam int CIP_INT_OVP     = 1;  // Over-voltage event
   localparam int CIP_INT_OTP     = 2;  // Over-temperature event
   localparam int CIP_INT_CLEARED = 3;  // Protection cleared event
   localparam int CIP_SW1_USB     = 0;  // USB pair
   localparam int CIP_SW1_UART    = 1;  // UART pair
   localparam int CIP_SW2_SPK     = 0;  // Speaker pair
   localparam int CIP_SW2_MIC     = 1;  // Microphone path
   localparam int CIP_SW2_PWR     = 2;  // Power switch request

   // ***************************************************************
   // Reset values and codes
   // ***************************************************************
   localparam logic [3:0] CIP_MASK_RESET  = 4'h0;
   localparam logic [2:0] CIP_SW_RESET    = 3'h0;
   localparam logic [4:0] CIP_ID_OPEN     = 5'h1f;  // Floating line
   localparam logic [4:0] CIP_ID_CARKIT1  = 5'h17;
   localparam logic [4:0] CIP_ID_CARKIT2  = 5'h1b;
   localparam logic [4:0] CIP_ID_UART1    = 5'h0e;
   localparam logic [4:0] CIP_ID_UART2    = 5'h0f;
   localparam logic [4:0] CIP_ID_USB1     = 5'h10;
   localparam logic [4:0] CIP_ID_USB2     = 5'h11;
   localparam logic [2:0] CIP_OTP_LIMIT   = 3'h7;   // Events before lock-out

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CIP_CLK_MHZ     = 25;
   localparam int CIP_OVP_OFF_NS  = 1000;  // Longest switch-off time
   localparam int CIP_OVP_CYCLES  = (CIP_OVP_OFF_NS * CIP_CLK_MHZ) / 1000;

   // ***************************************************************
   // Supply types
   // ***************************************************************
   typedef enum logic [2:0] {
      CIP_TYPE_NONE    = 3'b000,
      CIP_TYPE_USB     = 3'b001,
      CIP_TYPE_USBCHG  = 3'b010,
      CIP_TYPE_DEDCHG  = 3'b011,
      CIP_TYPE_CARKIT1 = 3'b100,
      CIP_TYPE_CARKIT2 = 3'b101,
      CIP_TYPE_OTHER   = 3'b110
   } cip_type_e;

   // Identification states
   typedef enum logic [1:0] {
      CIP_ST_IDLE  = 2'b00,
      CIP_ST_PROBE = 2'b01,
      CIP_ST_DONE  = 2'b10
   } cip_state_e;

endpackage

//--- cip_ctrl.sv

module cip_ctrl
   import cip_pkg::*;
(
   input  wire logic       clk_in,                 // 25 MHz clock
   input  wire logic       reset_n_in,             // Async reset
   input  wire logic       bus_power_present_in,   // VBUS comparator
   input  wire logic       data_lines_shorted_in,  // Short probe result
   input  wire logic       charger_port_seen_in,   // Charger probe result
   input  wire logic       probe_done_in,          // Probe finished
   input  wire logic       id_line_open_in,        // ID comparator
   input  wire logic [4:0] id_code_in,             // ID converter code
   input  wire logic       core_power_good_in,     // VDD above threshold
   input  wire logic       host_io_supply_in,      // Host I/O supply
   input  wire logic       overvoltage_in,         // Over-voltage comparator
   input  wire logic       overtemp_in,            // Over-temperature comparator
   input  wire logic [3:0] addr_in,                // Register address
   input  wire logic [7:0] wdata_in,               // Write data
   input  wire logic       wr_in,                  // Write strobe
   input  wire logic       rd_in,                  // Read strobe
   output logic      [7:0] rdata_out,              // Read data
   output logic            probe_start_out,        // Start line probe
   output logic            int_n_out,              // Interrupt, open drain
   output logic            int_oe_out,             // Interrupt enable
   output logic            usb_switch_out,         // USB pair
   output logic            uart_switch_out,        // UART pair
   output logic            speaker_switch_out,     // Speaker paths
   output logic            mic_switch_out,         // Microphone path
   output logic            bus_power_switch_out    // Power switch
);

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   localparam int NS = 9;
   localparam logic [NS-1:0] SYNC_IDLE = 9'h010;  // ID line idles open
   logic [NS-1:0] raw;     // Asynchronous levels
   logic [NS-1:0] meta_r;  // First stage
   logic [NS-1:0] sync_r;  // Second stage
   logic [4:0]    code_meta_r;
   logic [4:0]    code_r;

   assign raw = {bus_power_present_in, data_lines_shorted_in, charger_port_seen_in,
                 probe_done_in, id_line_open_in, core_power_good_in,
                 host_io_supply_in, overvoltage_in, overtemp_in};

   // Two flops for each pin
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_r      <= SYNC_IDLE;
         sync_r      <= SYNC_IDLE;
         code_meta_r <= 5'h00;
         code_r      <= 5'h00;
      end else begin
         // Shift pins in
         meta_r      <= raw;
         sync_r      <= meta_r;
         code_meta_r <= id_code_in;
         code_r      <= code_meta_r;
      end
   end

   // Synchronised levels, in pin order
   logic vbus_s;
   logic short_s;
   logic chg_s;
   logic done_s;
   logic open_s;
   logic vdd_s;
   logic vio_s;
   logic ovp_s;
   logic otp_s;
   assign {vbus_s, short_s, chg_s, done_s, open_s, vdd_s, vio_s, ovp_s, otp_s} = sync_r;

   // ***************************************************************
   // Identification machine
   // ***************************************************************
   cip_state_e state_r;        // Current state
   logic [3:0] status_r;       // Latched detection flags
   logic [4:0] id_result_r;    // Latched code
   cip_type_e  type_r;         // Classified supply
   logic       test_uart_r;    // UART test cable seen
   logic       test_usb_r;     // USB test cable seen
   logic       event_a_set;     // Event_a event pulse
   logic       attached;       // Accessory present
   logic       open_d_r;       // Previous ID open level
   logic       vbus_d_r;       // Previous bus power level
   logic       detach;         // Detach pulse
   logic [4:0] eff_code;       // Code seen by the latch

   // Presence and detach
   assign attached = vbus_s | ~open_s;
   assign detach   = (vbus_d_r & ~vbus_s & open_s) | (~open_d_r & open_s & ~vbus_s);
   assign eff_code = open_s ? CIP_ID_OPEN : code_r;

   // Classify latched results
   function automatic cip_type_e classify(input logic v, input logic s,
                                          input logic c, input logic o,
                                          input logic [4:0] k);
      cip_type_e t;
      // Unknown by default
      t = CIP_TYPE_OTHER;
      if (!v) begin
         t = CIP_TYPE_NONE;
      end else if (o && k == CIP_ID_OPEN) begin
         if (!s && !c) t = CIP_TYPE_USB;
         else if (!s && c) t = CIP_TYPE_USBCHG;
         else if (s && !c) t = CIP_TYPE_DEDCHG;
      end else if (!o && s && !c) begin
         if (k == CIP_ID_CARKIT1) t = CIP_TYPE_CARKIT1;
         else if (k == CIP_ID_CARKIT2) t = CIP_TYPE_CARKIT2;
      end
      return t;
   endfunction

   // Edge history for detach
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         open_d_r <= 1'b1;
         vbus_d_r <= 1'b0;
      end else begin
         open_d_r <= open_s;
         vbus_d_r <= vbus_s;
      end
   end

   // State sequencing
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r <= CIP_ST_IDLE;
      end else if (!vdd_s) begin
         state_r <= CIP_ST_IDLE;
      end else begin
         unique case (state_r)
            CIP_ST_IDLE: begin
               // Wait for accessory
               if (attached) state_r <= CIP_ST_PROBE;
            end
            CIP_ST_PROBE: begin
               // Until result or detach
               if (!attached) state_r <= CIP_ST_IDLE;
               else if (done_s || !vbus_s) state_r <= CIP_ST_DONE;
            end
            CIP_ST_DONE: begin
               // Hold until detach
               if (!attached) state_r <= CIP_ST_IDLE;
            end
         endcase
      end
   end

   // Probe handshake
   assign probe_start_out = (state_r == CIP_ST_PROBE) & vbus_s;
   assign event_a_set      = (state_r == CIP_ST_PROBE) & vdd_s & attached & (done_s | ~vbus_s);

   // Latch results on completion
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         status_r    <= 4'h0;
         id_result_r <= CIP_ID_OPEN;
         type_r      <= CIP_TYPE_NONE;
         test_uart_r <= 1'b0;
         test_usb_r  <= 1'b0;
      end else if (detach) begin
         // Forget accessory
         type_r      <= CIP_TYPE_NONE;
         test_uart_r <= 1'b0;
         test_usb_r  <= 1'b0;
      end else if (event_a_set) begin
         // Capture results
         status_r    <= {vbus_s, vbus_s & short_s, vbus_s & chg_s, open_s};
         id_result_r <= eff_code;
         type_r      <= classify(vbus_s, short_s, chg_s, open_s, eff_code);
         test_uart_r <= (eff_code == CIP_ID_UART1) | (eff_code == CIP_ID_UART2);
         test_usb_r  <= (eff_code == CIP_ID_USB1) | (eff_code == CIP_ID_USB2);
      end
   end

   // ***************************************************************
   // Power switch protection
   // ***************************************************************
   logic       ovp_trip;      // Over-voltage present
   logic       otp_off_r;     // Thermal shutdown active
   logic [2:0] otp_count_r;   // Thermal events this attachment
   logic       locked;        // Lock-out until detach
   logic       ovp_d_r;       // Previous over-voltage level
   logic       otp_rise;      // Thermal event pulse
   logic       otp_fall;      // Cooling pulse

   // Protection conditions
   assign ovp_trip = ovp_s;   // Off within two cycles
   assign otp_rise = otp_s & ~otp_off_r;
   assign otp_fall = ~otp_s & otp_off_r;
   assign locked   = (otp_count_r == CIP_OTP_LIMIT);

   // Thermal shutdown state
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         otp_off_r <= 1'b0;
         ovp_d_r   <= 1'b0;
      end else begin
         otp_off_r <= otp_s;
         ovp_d_r   <= ovp_s;
      end
   end

   // Thermal event counter
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         otp_count_r <= 3'h0;
      end else if (detach) begin
         otp_count_r <= 3'h0;
      end else if (otp_rise && !locked) begin
         // Count to lock-out
         otp_count_r <= otp_count_r + 3'h1;
      end
   end

   // ***************************************************************
   // Register file
   // ***************************************************************
   logic [3:0] int_r;       // Event flags
   logic [3:0] mask_r;      // Event masks
   logic [1:0] sw1_r;       // Switch control 1
   logic [2:0] sw2_r;       // Switch control 2
   logic [3:0] int_set;     // Event pulses
   logic       bus_ok;      // Host side powered
   logic       rd_int;      // Flag register read

   // Access gating
   assign bus_ok  = vio_s;
   assign rd_int  = rd_in & bus_ok & (addr_in == CIP_ADDR_INT);
   assign int_set = {ovp_d_r & ~ovp_s | (otp_fall & ~locked),
                     otp_rise,
                     ovp_s & ~ovp_d_r,
                     event_a_set};

   // Sticky flags, set wins over read-clear
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         int_r <= 4'h0;
      end else begin
         int_r <= (rd_int ? 4'h0 : int_r) | int_set;
      end
   end

   // Writable control registers
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mask_r <= CIP_MASK_RESET;
         sw1_r  <= CIP_SW_RESET[1:0];
         sw2_r  <= CIP_SW_RESET;
      end else if (event_a_set || detach) begin
         // Open all switches
         sw1_r <= CIP_SW_RESET[1:0];
         sw2_r <= CIP_SW_RESET;
      end else if (wr_in && bus_ok) begin
         unique case (addr_in)
            CIP_ADDR_INT_MASK: mask_r <= wdata_in[3:0];
            CIP_ADDR_SW_CTL1:  sw1_r  <= wdata_in[1:0];
            CIP_ADDR_SW_CTL2:  sw2_r  <= wdata_in[2:0];
            default: ;
         endcase
      end
   end

   // Read data one cycle after strobe
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in && bus_ok) begin
         unique case (addr_in)
            CIP_ADDR_STATUS:   rdata_out <= {4'h0, status_r[3:1], open_s};
            CIP_ADDR_ID_CODE:  rdata_out <= {3'h0, id_result_r};
            CIP_ADDR_INT:      rdata_out <= {4'h0, int_r};
            CIP_ADDR_INT_MASK: rdata_out <= {4'h0, mask_r};
            CIP_ADDR_SW_CTL1:  rdata_out <= {6'h00, sw1_r};
            CIP_ADDR_SW_CTL2:  rdata_out <= {5'h00, sw2_r};
            CIP_ADDR_TYPE:     rdata_out <= {locked, otp_count_r, 1'b0, type_r};
            default:           rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // ***************************************************************
   // Interrupt pin
   // ***************************************************************
   logic irq_r;  // Pin drive state

   // Registered enable
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= vio_s & (|(int_r & ~mask_r));
      end
   end
   // Open drain pin
   assign int_n_out  = 1'b0;
   assign int_oe_out = irq_r;

   // ***************************************************************
   // Switch outputs
   // ***************************************************************
   logic test_cable;  // Test cable owns the switches
   // Either cable
   assign test_cable = test_uart_r | test_usb_r;

   // Signal paths
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         usb_switch_out     <= 1'b0;
         uart_switch_out    <= 1'b0;
         speaker_switch_out <= 1'b0;
         mic_switch_out     <= 1'b0;
      end else if (test_cable) begin
         // Cable owns paths
         usb_switch_out     <= test_usb_r;
         uart_switch_out    <= test_uart_r;
         speaker_switch_out <= 1'b0;
         mic_switch_out     <= 1'b0;
      end else begin
         usb_switch_out     <= sw1_r[CIP_SW1_USB];
         uart_switch_out    <= sw1_r[CIP_SW1_UART];
         speaker_switch_out <= sw2_r[CIP_SW2_SPK];
         mic_switch_out     <= sw2_r[CIP_SW2_MIC];
      end
   end

   // Power switch, protection overrides all
   always_comb begin
      if (ovp_trip || otp_s || otp_off_r || locked) begin
         bus_power_switch_out = 1'b0;
      end else if (!vdd_s) begin
         // Bus power mode
         bus_power_switch_out = vbus_s;
      end else if (test_uart_r) begin
         bus_power_switch_out = 1'b0;
      end else if (test_usb_r) begin
         bus_power_switch_out = vbus_s;
      end else if (type_r != CIP_TYPE_NONE && type_r != CIP_TYPE_OTHER) begin
         bus_power_switch_out = vbus_s;
      end else begin
         bus_power_switch_out = vbus_s & sw2_r[CIP_SW2_PWR];
      end
   end

endmodule

//--- cip_probe_model.sv
// ***************************************************************
// Line probe stand-in
// ***************************************************************
module cip_probe_model (
   input  wire logic       clk_in,     // Block clock
   input  wire logic       start_in,   // Probe request from the block
   input  wire logic       short_in,   // Short result to report
   input  wire logic       chg_in,     // Charger result to report
   input  wire logic [3:0] delay_in,   // Probe length in cycles
   output logic            done_out,   // Probe finished
   output logic            short_out,  // Short result
   output logic            chg_out     // Charger result
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] cnt_r;  // Cycles spent probing

   // Count while requested, then hold done until the request drops
   always_ff @(posedge clk_in) begin
      if (!start_in) begin
         cnt_r    <= 4'h0;
         done_out <= 1'b0;
      end else if (cnt_r == delay_in) begin
         done_out <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   // Results inverted until done
   assign short_out = done_out ? short_in : ~short_in;
   assign chg_out   = done_out ? chg_in : ~chg_in;
endmodule

//--- cip_ctrl_properties.sv
// ***************************************************************
// Port checker for the controller
// ***************************************************************
module cip_ctrl_chk (
   input wire logic       clk_in,                // Clock
   input wire logic       reset_n_in,            // Async reset
   input wire logic       bus_power_present_in,  // Bus power
   input wire logic       id_line_open_in,       // ID open
   input wire logic       core_power_good_in,    // Core power
   input wire logic       host_io_supply_in,     // Host supply
   input wire logic       overvoltage_in,        // Over-voltage
   input wire logic       overtemp_in,           // Over-temperature
   input wire logic       rd_in,                 // Read strobe
   input wire logic [7:0] rdata_out,             // Read data
   input wire logic       probe_start_out,       // Probe request
   input wire logic       int_n_out,             // Interrupt value
   input wire logic       int_oe_out,            // Interrupt enable
   input wire logic       usb_switch_out,        // USB pair
   input wire logic       uart_switch_out,       // UART pair
   input wire logic       bus_power_switch_out   // Power switch
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);

   a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside answer cycle");
   a_no_host_int: assert property (!host_io_supply_in [*4] |-> !int_oe_out)
      else $error("interrupt without host supply");
   a_no_host_read: assert property (!host_io_supply_in [*4] ##0 rd_in |=> rdata_out == 8'h00)
      else $error("read answered without host supply");
   a_ovp_off: assert property (overvoltage_in [*4] |-> !bus_power_switch_out)
      else $error("power switch on during over-voltage");
   a_ovp_prompt: assert property ($rose(overvoltage_in) |-> ##[0:24] !bus_power_switch_out)
      else $error("power switch slow to open");
   a_otp_off: assert property (overtemp_in [*4] |-> !bus_power_switch_out)
      else $error("power switch on during over-temperature");
   a_probe_vdd: assert property (!core_power_good_in [*4] |-> !probe_start_out)
      else $error("probe without core power");
   a_bus_power_mode: assert property ((!core_power_good_in && bus_power_present_in &&
      !overvoltage_in && !overtemp_in) [*4] |-> bus_power_switch_out)
      else $error("power switch off in bus power mode");
   a_int_open_drain: assert property (int_n_out == 1'b0)
      else $error("interrupt pin value not low");
   a_detach_open: assert property ($rose(id_line_open_in) && !bus_power_present_in
      |-> ##4 (!usb_switch_out && !uart_switch_out))
      else $error("switches left closed after detach");

   c_interrupt: cover property ($rose(int_oe_out));
   c_power_cut: cover property ($fell(bus_power_switch_out));
   c_uart_cable: cover property ($rose(uart_switch_out));
endmodule

bind cip_ctrl cip_ctrl_chk chk (
   .clk_in(clk_in), .reset_n_in(reset_n_in), .bus_power_present_in(bus_power_present_in),
   .id_line_open_in(id_line_open_in), .core_power_good_in(core_power_good_in),
   .host_io_supply_in(host_io_supply_in), .overvoltage_in(overvoltage_in),
   .overtemp_in(overtemp_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .probe_start_out(probe_start_out), .int_n_out(int_n_out), .int_oe_out(int_oe_out),
   .usb_switch_out(usb_switch_out), .uart_switch_out(uart_switch_out),
   .bus_power_switch_out(bus_power_switch_out)
);

//--- testbench.sv
module testbench;
   import cip_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************************
   // Stimulus and observation
   // ***************************************************************
   logic clk, rst_n, vbus, sh, ch, op, vdd, host, ov, ot, wr_s, rd_s;
   logic done, msh, mch, pst, intn, intoe, usb, uart, spk, microphone_pin, pwr;
   logic [4:0] code;
   logic [3:0] addr, dly;
   logic [7:0] wdata, rdata, d, w;
   int         errors, total_checks, i, k;
   // Cases: {vbus, short, charger, open, code}
   logic [8:0] tbl [9] = '{9'h13f, 9'h17f, 9'h1bf, 9'h197, 9'h19b,
                           9'h00e, 9'h00f, 9'h110, 9'h111};

   cip_probe_model pm (.clk_in(clk), .start_in(pst), .short_in(sh), .chg_in(ch),
      .delay_in(dly), .done_out(done), .short_out(msh), .chg_out(mch));

   cip_ctrl dut (.clk_in(clk), .reset_n_in(rst_n), .bus_power_present_in(vbus),
      .data_lines_shorted_in(msh), .charger_port_seen_in(mch), .probe_done_in(done),
      .id_line_open_in(op), .id_code_in(code), .core_power_good_in(vdd),
      .host_io_supply_in(host), .overvoltage_in(ov), .overtemp_in(ot), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
      .probe_start_out(pst), .int_n_out(intn), .int_oe_out(intoe), .usb_switch_out(usb),
      .uart_switch_out(uart), .speaker_switch_out(spk), .mic_switch_out(microphone_pin),
      .bus_power_switch_out(pwr));

   always #20 clk = ~clk;

   // ***************************************************************
   // Reference model and helpers
   // ***************************************************************
   function automatic logic [7:0] exp_type(input logic [8:0] c);
      cip_type_e t;
      t = CIP_TYPE_OTHER;
      if (!c[8]) begin
         t = CIP_TYPE_NONE;
      end else if (c[5] && c[4:0] == CIP_ID_OPEN) begin
         if (c[7:6] == 2'b00) t = CIP_TYPE_USB;
         if (c[7:6] == 2'b01) t = CIP_TYPE_USBCHG;
         if (c[7:6] == 2'b10) t = CIP_TYPE_DEDCHG;
      end else if (!c[5] && c[7:6] == 2'b10) begin
         if (c[4:0] == CIP_ID_CARKIT1) t = CIP_TYPE_CARKIT1;
         if (c[4:0] == CIP_ID_CARKIT2) t = CIP_TYPE_CARKIT2;
      end
      return {5'h00, t};
   endfunction

   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic give_verdict();
      if (errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
   endtask

   // Answer is sampled in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic event_a(input logic [8:0] c);
      @(posedge clk);
      {vbus, sh, ch, op, code} <= c;
      dly <= 4'($urandom_range(1, 12));
   endtask

   task automatic detach();
      @(posedge clk);
      vbus <= 1'b0;
      op   <= 1'b1;
      settle(12);
      rd(CIP_ADDR_INT, d);
   endtask

   task automatic wait_int();
      for (k = 0; intoe !== 1'b1; k++) begin
         if (k > 300) begin
            errors++;
            give_verdict();
         end
         settle(1);
      end
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      {clk, rst_n, vbus, sh, ch, ov, ot, wr_s, rd_s, addr, wdata} = '0;
      {op, vdd, host, code, dly} = {3'b111, 5'h1f, 4'h4};
      void'($urandom(15));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      settle(3);
      check("int_oe reset", {7'h0, intoe}, 8'h00);
      // Every supply type and test cable
      for (i = 0; i < 9; i++) begin
         event_a(tbl[i]);
         wait_int();
         rd(CIP_ADDR_TYPE, d);
         check("type", {5'h0, d[2:0]}, exp_type(tbl[i]));
         rd(CIP_ADDR_ID_CODE, d);
         check("id code", d, {3'h0, tbl[i][4:0]});
         rd(CIP_ADDR_STATUS, d);
         if (i < 5) check("status", {4'h0, d[3:0]}, {4'h0, tbl[i][8:5]});
         rd(CIP_ADDR_INT, d);
         check("event_a flag", {7'h0, d[CIP_INT_EVENT_A]}, 8'h01);
         settle(2);
         check("int after read", {7'h0, intoe}, 8'h00);
         check("switches", {4'h0, uart, usb, spk, microphone_pin},
               {4'h0, tbl[i][4:1] == 4'h7, tbl[i][4:1] == 4'h8, 2'b00});
         if (i > 4) check("cable power", {7'h0, pwr}, {7'h0, tbl[i][8]});
         detach();
      end
      // Host switch control, then over-voltage
      event_a(tbl[2]);
      wait_int();
      rd(CIP_ADDR_INT, d);
      w = 8'($urandom);
      wr(CIP_ADDR_SW_CTL1, {6'h0, w[1:0]});
      wr(CIP_ADDR_SW_CTL2, {5'h0, 1'b1, w[3:2]});
      settle(2);
      check("host switches", {4'h0, microphone_pin, spk, uart, usb}, {4'h0, w[3:0]});
      check("power on", {7'h0, pwr}, 8'h01);
      @(posedge clk) ov <= 1'b1;
      settle(4);
      check("ovp power", {7'h0, pwr}, 8'h00);
      rd(CIP_ADDR_INT, d);
      check("ovp flag", {7'h0, d[CIP_INT_OVP]}, 8'h01);
      @(posedge clk) ov <= 1'b0;
      settle(4);
      rd(CIP_ADDR_INT, d);
      check("ovp cleared", {7'h0, d[CIP_INT_CLEARED]}, 8'h01);
      // Over-temperature until lock-out
      for (i = 1; i <= 7; i++) begin
         @(posedge clk) ot <= 1'b1;
         settle(4);
         check("otp power", {7'h0, pwr}, 8'h00);
         rd(CIP_ADDR_INT, d);
         check("otp flag", {7'h0, d[CIP_INT_OTP]}, 8'h01);
         @(posedge clk) ot <= 1'b0;
         settle(4);
         check("cool power", {7'h0, pwr}, {7'h0, i < 7});
         rd(CIP_ADDR_INT, d);
         check("otp cleared", {7'h0, d[CIP_INT_CLEARED]}, {7'h0, i < 7});
      end
      rd(CIP_ADDR_TYPE, d);
      check("locked", {4'h0, d[7:4]}, {4'h0, 1'b1, CIP_OTP_LIMIT});
      detach();
      event_a(tbl[2]);
      wait_int();
      check("relock power", {7'h0, pwr}, 8'h01);
      rd(CIP_ADDR_TYPE, d);
      check("count cleared", {4'h0, d[7:4]}, 8'h00);
      detach();
      // Masked event_a
      wr(CIP_ADDR_INT_MASK, 8'h01);
      event_a(tbl[0]);
      settle(40);
      check("masked int", {7'h0, intoe}, 8'h00);
      rd(CIP_ADDR_INT, d);
      check("masked flag", {7'h0, d[CIP_INT_EVENT_A]}, 8'h01);
      rd(CIP_ADDR_INT_MASK, d);
      check("mask readback", d, 8'h01);
      wr(CIP_ADDR_INT_MASK, {4'h0, CIP_MASK_RESET});
      detach();
      // No host traffic without host supply
      @(posedge clk) host <= 1'b0;
      settle(4);
      wr(CIP_ADDR_INT_MASK, 8'h01);
      rd(CIP_ADDR_STATUS, d);
      check("unpowered read", d, 8'h00);
      @(posedge clk) host <= 1'b1;
      settle(4);
      rd(CIP_ADDR_INT_MASK, d);
      check("refused write", d, 8'h00);
      rd(4'hf, d);
      check("unmapped", d, 8'h00);
      // Bus power with core supply down
      @(posedge clk);
      vdd  <= 1'b0;
      vbus <= 1'b1;
      settle(8);
      check("no probe", {7'h0, pst}, 8'h00);
      check("bus power mode", {7'h0, pwr}, 8'h01);
      give_verdict();
   end
endmodule
